// *** logic/tup_cfg.svh ***
/*
 Constants of the tape unit host port: register offsets, field positions,
 reset values and timing counts. Assumes a 100 MHz core clock.
*/
`ifndef TUP_CFG_SVH
`define TUP_CFG_SVH

// Core clock
`define TUP_CLK_MHZ 100
// Oscillator output, half period in ns
`define TUP_OSC_HALF_NS 200
`define TUP_OSC_HALF_CYC ((`TUP_OSC_HALF_NS * `TUP_CLK_MHZ) / 1000)
// Block sensed pulse, nominal ns
`define TUP_BLOCK_NS 250
`define TUP_BLOCK_CYC ((`TUP_BLOCK_NS * `TUP_CLK_MHZ) / 1000)
// End of data pulse, ns
`define TUP_EOD_NS 800
`define TUP_EOD_CYC ((`TUP_EOD_NS * `TUP_CLK_MHZ) / 1000)
// Reset procedure after reset release, us
`define TUP_RST_PROC_US 10
`define TUP_RST_PROC_CYC (`TUP_RST_PROC_US * `TUP_CLK_MHZ)

// Register byte offsets
`define TUP_REG_CTRL 8'h00
`define TUP_REG_STATUS 8'h04
`define TUP_REG_LASTCMD 8'h08
// Control fields
`define TUP_CTRL_PANEL_LSB 0
`define TUP_CTRL_DIAG_BIT 2
`define TUP_CTRL_RESET 3'h0
// Panel density switch codes
`define TUP_PANEL_PE 2'h0
`define TUP_PANEL_GCR 2'h1
`define TUP_PANEL_SYSTEM 2'h2

`endif

// *** logic/tup_host_port.sv ***
/*
 Host parallel port of a tape unit: command start, density choice,
 character handshake, status multiplexer, oscillator and reset.
 Assumes a tape engine on the same clock that moves tape and formats
 data, and a host whose pins arrive asynchronously.
*/
// Functional notes
// - Fixed panel density at BOT overrides the host density lines for writing.
// - System-select panel at BOT takes density lines: 0 is PE, 1 GCR.
// - Density changes only on write at BOT; otherwise identification burst density.
// - On write, request asks a character; host answers acknowledge or terminate.
// - On read, request marks a valid character; host answer means taken.
// - Request held until answer; host holds acknowledge until request drops.
// - Terminate during read stops character transfer.
// - Terminate after block pulse stops block spacing.
// - After terminate busy drops only when engine finishes positioning.
// - System reset aborts, holds busy, refuses commands, clears errors, keeps density.
// - Reset halts formatting and motion and leaves diagnostic mode.
// - Multiplexer codes 0 to 3 select status byte 0 to 3.
// - Status bytes valid only as ending status after busy drops.
// - Nine data lines keep odd parity; data bit 7 least significant.
// - Expecting data only for write commands, held until next command.
// - Block pulse per spaced block and per tape mark on reads.
// - Oscillator output runs continuously at 2.5 MHz.
// - Reads end with an 800 ns end of data pulse.
// - Busy from command acceptance until completion or reject.
// - Identification flag during burst procedure; on reads it finds format.
// - Failed identification gives reject and keeps identification flag.
// - Tape mark flag set by mark; cleared by next command except three.
// - Start taken only while not busy; command and density captured then.
// - Four command lines decode sixteen operations.
`timescale 1ns/1ps
`include "tup_cfg.svh"

module tup_host_port
    import tup_pkg::*;
#(
    parameter int OSC_HALF_CYC = `TUP_OSC_HALF_CYC,
    parameter int BLOCK_CYC = `TUP_BLOCK_CYC,
    parameter int EOD_CYC = `TUP_EOD_CYC,
    parameter int RST_PROC_CYC = `TUP_RST_PROC_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    output logic wbAck,
    // Host pins in
    input wire tup_host_in_t hostIn,
    // Host pins out
    output logic [8:0] dataOut,
    output logic dataOe,
    output logic busy,
    output logic xferReq,
    output logic expectingData,
    output logic blockSensed,
    output logic endOfDataPulse,
    output logic identBurstFlag,
    output logic tapeMarkFlag,
    output logic reject,
    output logic [8:0] statusMuxOut,
    output logic oscOut,
    // Tape engine
    input wire logic engAtBot,
    input wire logic engIdOk,
    input wire logic engIdFail,
    input wire logic engIdGcr,
    input wire logic engRdValid,
    input wire logic [7:0] engRdData,
    input wire logic engRdLast,
    input wire logic engWrReq,
    input wire logic engBlock,
    input wire logic engTapeMark,
    input wire logic engDone,
    input wire tup_status_t engStatus,
    output logic engStart,
    output tup_cmd_t engCmd,
    output logic engGcr,
    output logic engTerm,
    output logic engAbort,
    output logic engDiag,
    output logic engRdTake,
    output logic engWrValid,
    output logic [7:0] engWrData
);
    function automatic logic isRead(input tup_cmd_t c);
        return c == CMD_READ_FWD || c == CMD_READ_BWD;
    endfunction : isRead

    function automatic logic isWrite(input tup_cmd_t c);
        return c == CMD_WRITE_BLOCK || c == CMD_LOOP_WRITE_READ;
    endfunction : isWrite

    tup_host_in_t syncA_reg, syncB_reg;
    logic startPrev_reg, rstPrev_reg;
    tup_state_t st_reg, st_next;
    tup_cmd_t cmd_reg;
    logic [1:0] panel_reg;
    logic [15:0] rstCnt_reg;
    logic [7:0] oscCnt_reg, blkCnt_reg, eodCnt_reg;
    logic termSeen_reg, lastChar_reg, ctrlDiag_reg;
    logic [8:0] end0_reg, end1_reg, end2_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
            startPrev_reg <= 1'b0;
            rstPrev_reg <= 1'b0;
        end else begin
            syncA_reg <= hostIn;
            syncB_reg <= syncA_reg;
            startPrev_reg <= syncB_reg.start;
            rstPrev_reg <= syncB_reg.sysReset;
        end
    end

    wire logic answer = syncB_reg.xferAck | syncB_reg.terminate;
    wire logic hostRst = syncB_reg.sysReset;
    wire logic startRise = syncB_reg.start & ~startPrev_reg;
    wire tup_cmd_t newCmd = tup_cmd_t'(syncB_reg.cmdSel);
    wire logic accept = (st_reg == ST_IDLE) & startRise & ~hostRst;
    wire logic rwCmd = isRead(newCmd) | isWrite(newCmd);
    wire logic rdCmd = isRead(cmd_reg);
    wire logic spaceCmd = cmd_reg == CMD_SPACE_BACK_BLOCK || cmd_reg == CMD_SPACE_FWD_BLOCK;
    wire logic keepMark = newCmd == CMD_DRIVE_CLEAR || newCmd == CMD_SENSE || newCmd == CMD_NO_OP;

    // Next state
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            ST_IDLE: begin
                if (accept) begin
                    st_next = (rwCmd && engAtBot) ? ST_IDENT : ST_RUN;
                end
            end
            ST_IDENT: begin
                if (engIdFail) begin
                    st_next = ST_IDLE;
                end else if (engIdOk) begin
                    st_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (engDone) begin
                    st_next = ST_IDLE;
                end else if ((isWrite(cmd_reg) && engWrReq) || (rdCmd && engRdValid)) begin
                    st_next = ST_REQ;
                end
            end
            ST_REQ: st_next = answer ? ST_ACKLOW : ST_REQ;
            ST_ACKLOW: begin
                if (!answer) begin
                    st_next = termSeen_reg ? ST_FINISH : ST_RUN;
                end
            end
            ST_FINISH: st_next = engDone ? ST_IDLE : ST_FINISH;
            ST_RST: st_next = (!hostRst && rstCnt_reg == 16'h0000) ? ST_IDLE : ST_RST;
            default: st_next = ST_IDLE;
        endcase
        if (hostRst) begin
            st_next = ST_RST;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rstCnt_reg <= 16'h0000;
        end else if (hostRst) begin
            rstCnt_reg <= 16'(RST_PROC_CYC);
        end else if (rstCnt_reg != 16'h0000) begin
            rstCnt_reg <= rstCnt_reg - 16'h0001;
        end
    end

    assign busy = st_reg != ST_IDLE;
    assign xferReq = st_reg == ST_REQ;
    assign engStart = accept;
    assign engCmd = cmd_reg;
    assign engAbort = st_reg == ST_RST;
    assign engDiag = ctrlDiag_reg;
    wire logic taken = (st_reg == ST_REQ) & answer;
    assign engTerm = (taken & syncB_reg.terminate)
        | ((st_reg == ST_RUN) & spaceCmd & syncB_reg.terminate & ~termSeen_reg);
    assign engRdTake = taken & rdCmd;
    assign engWrValid = taken & isWrite(cmd_reg);
    assign engWrData = syncB_reg.data[7:0];
    assign dataOe = rdCmd & busy & (st_reg != ST_RST);

    // Command capture, density, read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_reg <= CMD_NO_OP;
            engGcr <= 1'b0;
            dataOut <= 9'h100;
            termSeen_reg <= 1'b0;
            lastChar_reg <= 1'b0;
        end else begin
            if (accept) begin
                cmd_reg <= newCmd;
                termSeen_reg <= 1'b0;
                // density chosen at write from BOT
                if (isWrite(newCmd) && engAtBot) begin
                    engGcr <= (panel_reg == `TUP_PANEL_SYSTEM) ? syncB_reg.densitySelLo
                        : (panel_reg == `TUP_PANEL_GCR);
                end
            end
            // read from BOT takes burst density
            if (st_reg == ST_IDENT && engIdOk && rdCmd) begin
                engGcr <= engIdGcr;
            end
            if (taken && syncB_reg.terminate) begin
                termSeen_reg <= 1'b1;
            end
            if (st_reg == ST_RUN && spaceCmd && syncB_reg.terminate) begin
                termSeen_reg <= 1'b1;
            end
            if (st_reg == ST_RUN && rdCmd && engRdValid) begin
                dataOut <= {~^engRdData, engRdData};
                lastChar_reg <= engRdLast;
            end
        end
    end

    // Flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            expectingData <= 1'b0;
            identBurstFlag <= 1'b0;
            tapeMarkFlag <= 1'b0;
            reject <= 1'b0;
        end else begin
            if (accept) begin
                expectingData <= isWrite(newCmd);
                reject <= 1'b0;
                identBurstFlag <= rwCmd & engAtBot;
            end
            if (st_reg == ST_IDENT && engIdOk) begin
                identBurstFlag <= 1'b0;
            end
            if (st_reg == ST_IDENT && engIdFail) begin
                reject <= 1'b1;
            end
            // cleared by next command, set wins
            if (accept && !keepMark) begin
                tapeMarkFlag <= 1'b0;
            end
            if (busy && (engTapeMark || (engDone && cmd_reg == CMD_WRITE_MARK))) begin
                tapeMarkFlag <= 1'b1;
            end
            if (hostRst) begin
                reject <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blkCnt_reg <= 8'h00;
        end else if (busy && (engBlock && spaceCmd || engTapeMark && rdCmd)) begin
            blkCnt_reg <= 8'(BLOCK_CYC);
        end else if (blkCnt_reg != 8'h00) begin
            blkCnt_reg <= blkCnt_reg - 8'h01;
        end
    end
    assign blockSensed = blkCnt_reg != 8'h00;

    // end of data pulse after last character
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eodCnt_reg <= 8'h00;
        end else if (engRdTake && lastChar_reg) begin
            eodCnt_reg <= 8'(EOD_CYC);
        end else if (eodCnt_reg != 8'h00) begin
            eodCnt_reg <= eodCnt_reg - 8'h01;
        end
    end
    assign endOfDataPulse = eodCnt_reg != 8'h00;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oscCnt_reg <= 8'h00;
            oscOut <= 1'b0;
        end else if (oscCnt_reg == 8'(OSC_HALF_CYC - 1)) begin
            oscCnt_reg <= 8'h00;
            oscOut <= ~oscOut;
        end else begin
            oscCnt_reg <= oscCnt_reg + 8'h01;
        end
    end

    // ending status captured at completion; cleared by reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            end0_reg <= 9'h000;
            end1_reg <= 9'h000;
            end2_reg <= 9'h000;
        end else if (hostRst || accept) begin
            end0_reg <= 9'h000;
            end1_reg <= 9'h000;
            end2_reg <= 9'h000;
        end else if (busy && (engDone || engIdFail)) begin
            end0_reg <= engStatus.byte0;
            end1_reg <= engStatus.byte1;
            end2_reg <= engStatus.byte2;
        end
    end

    wire logic [8:0] muxSelected = (syncB_reg.muxSel == 3'h0) ? end0_reg
        : (syncB_reg.muxSel == 3'h1) ? end1_reg
        : (syncB_reg.muxSel == 3'h2) ? end2_reg
        : (syncB_reg.muxSel == 3'h3) ? engStatus.byte3 : 9'h000;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusMuxOut <= 9'h000;
        end else begin
            statusMuxOut <= muxSelected;
        end
    end

    // Wishbone slave, one wait state
    wire logic wbReq = wbCyc & wbStb & ~wbAck;
    wire logic hitCtrl = wbAdr == `TUP_REG_CTRL;
    wire logic hitStat = wbAdr == `TUP_REG_STATUS;
    wire logic hitCmd = wbAdr == `TUP_REG_LASTCMD;
    wire logic [31:0] rdMux = hitCtrl ? {29'h0, ctrlDiag_reg, panel_reg}
        : hitStat ? {21'h0, st_reg, 2'h0, reject, tapeMarkFlag, identBurstFlag,
            expectingData, engGcr, busy}
        : hitCmd ? {28'h0, cmd_reg} : 32'h0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wbAck <= 1'b0;
            wbDatO <= 32'h0;
            panel_reg <= 2'(`TUP_CTRL_RESET);
            ctrlDiag_reg <= 1'b0;
        end else begin
            wbAck <= wbReq;
            wbDatO <= wbReq ? rdMux : 32'h0;
            if (wbCyc && wbStb && wbAck && wbWe && hitCtrl && wbSel[0]) begin
                panel_reg <= wbDatI[`TUP_CTRL_PANEL_LSB +: 2];
                ctrlDiag_reg <= wbDatI[`TUP_CTRL_DIAG_BIT];
            end
            if (hostRst) begin
                ctrlDiag_reg <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_req_hold: assert property (xferReq && !answer |=> xferReq)
        else $error("request dropped before answer");
    a_busy_start: assert property (accept |=> busy)
        else $error("busy not raised on start");
    a_ident_fail: assert property (st_reg == ST_IDENT && engIdFail && !hostRst
        |=> identBurstFlag && reject && !busy)
        else $error("identification failure not rejected");
    a_eod_width: assert property ($rose(endOfDataPulse)
        |-> ##79 endOfDataPulse ##1 !endOfDataPulse)
        else $error("end of data pulse width wrong");
    a_block_width: assert property ($rose(blockSensed) && !engBlock && !engTapeMark
        |-> ##24 blockSensed ##1 !blockSensed or ##[1:24] (engBlock || engTapeMark))
        else $error("block pulse width wrong");
    a_osc_half: assert property ($rose(oscOut) |-> ##19 oscOut ##1 !oscOut)
        else $error("oscillator half period wrong");
    a_mux_byte2: assert property (syncB_reg.muxSel == 3'h2
        |=> statusMuxOut == $past(end2_reg))
        else $error("status byte 2 not selected");
    a_expect_wr: assert property (expectingData |-> isWrite(cmd_reg))
        else $error("expecting data on non-write command");
    a_reset_abort: assert property ($rose(hostRst) |=> st_reg == ST_RST && busy
        && end1_reg == 9'h000)
        else $error("reset did not abort");
    a_rst_density: assert property (st_reg == ST_RST |=> $stable(engGcr))
        else $error("density changed in reset");
    a_data_parity: assert property (dataOe |-> ^dataOut)
        else $error("read data parity not odd");

    c_write_xfer: cover property (engWrValid && syncB_reg.terminate);
    c_read_term: cover property (engRdTake && syncB_reg.terminate);
    c_ident_fail: cover property (st_reg == ST_IDENT && engIdFail);
    c_reset_done: cover property (st_reg == ST_RST ##1 st_reg == ST_IDLE);
endmodule : tup_host_port

// *** logic/tup_pkg.sv ***
/*
 Types of the tape unit host port: commands, states and carriers.
 Assumes tup_cfg.svh for numeric constants.
*/
package tup_pkg;
    typedef enum logic [3:0] {
        CMD_NO_OP = 4'h0, CMD_DRIVE_CLEAR = 4'h1, CMD_DIAG_SET = 4'h2,
        CMD_SENSE = 4'h3, CMD_READ_FWD = 4'h4, CMD_READ_BWD = 4'h5,
        CMD_WRITE_BLOCK = 4'h6, CMD_LOOP_WRITE_READ = 4'h7,
        CMD_SPACE_BACK_FILE = 4'h8, CMD_SPACE_BACK_BLOCK = 4'h9,
        CMD_SPACE_FWD_FILE = 4'hA, CMD_SPACE_FWD_BLOCK = 4'hB,
        CMD_WRITE_MARK = 4'hC, CMD_ERASE_GAP = 4'hD, CMD_REWIND = 4'hE,
        CMD_REWIND_UNLOAD = 4'hF
    } tup_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_IDENT = 3'h1, ST_RUN = 3'h2, ST_REQ = 3'h3,
        ST_ACKLOW = 3'h4, ST_FINISH = 3'h5, ST_RST = 3'h6
    } tup_state_t;

    typedef struct packed {
        logic start;
        logic [3:0] cmdSel;
        logic densitySelHi;
        logic densitySelLo;
        logic xferAck;
        logic terminate;
        logic sysReset;
        logic [2:0] muxSel;
        logic [8:0] data;
    } tup_host_in_t;

    typedef struct packed {
        logic [8:0] byte0;
        logic [8:0] byte1;
        logic [8:0] byte2;
        logic [8:0] byte3;
    } tup_status_t;
endpackage : tup_pkg

// *** sim/tup_host_model.sv ***
/*
 Host controller model: answers each character request.
 Assumes request and expecting-data outputs of the port on clk.
*/
`timescale 1ns/1ps
module tup_host_model (
    // Clock
    input wire logic clk,
    // From port
    input wire logic xferReq,
    input wire logic expectingData,
    // Control from bench
    input wire logic lastChar,
    input wire logic slow,
    input wire logic [7:0] wrByte,
    // To port
    output logic ack,
    output logic term,
    output logic [8:0] data
);
    initial begin
        ack = 1'b0;
        term = 1'b0;
        data = 9'h0AA;
        forever begin
            @(posedge clk);
            if (xferReq) begin
                if (expectingData) data <= {~^wrByte, wrByte};
                repeat (slow ? 5 : 1) @(posedge clk);
                if (lastChar) term <= 1'b1;
                else ack <= 1'b1;
                do @(posedge clk); while (xferReq);
                ack <= 1'b0;
                term <= 1'b0;
                data <= ~data;
            end
        end
    end
endmodule : tup_host_model

// *** sim/tup_host_port_tb.sv ***
/*
 Self-checking bench of the tape unit host port.
 Assumes the bench plays host pins, tape engine and Wishbone master.
*/
`timescale 1ns/1ps
module tup_host_port_tb;
    import tup_pkg::*;
    localparam int BLK = 25;
    localparam int EOD = 80;
    localparam int RP = 20;
    localparam logic [4:0] P_DONE = 5'h10, P_IDOK = 5'h08, P_FAIL = 5'h04;
    localparam logic [4:0] P_MARK = 5'h02, P_BLK = 5'h01;
    logic clk, rst, wbCyc, wbStb, wbWe, wbAck, start, dLo, sysRst, bTerm, last, slow;
    logic [7:0] wbAdr, wrByte, rdData, engWrData, b;
    logic [31:0] wbDatI, wbDatO, q;
    logic [3:0] cmdSel;
    logic [2:0] muxSel;
    logic [8:0] dataOut, statusMuxOut, pData;
    logic dataOe, busy, xferReq, expectingData, blockSensed, endOfDataPulse, identBurstFlag;
    logic tapeMarkFlag, reject, oscOut, pAck, pTerm, engGcr, engTerm, engAbort, engRdTake;
    logic engWrValid, atBot, idOk, idFail, rdValid, rdLast, wrReq, blk, tMark, done;
    logic engStart, engDiag;
    logic [35:0] stat;
    tup_cmd_t engCmd;
    tup_host_in_t hostIn;
    int seed = 32'h5e7a;
    int failures = 0;
    int nCompared = 0;
    int cycles = 0;
    int oscHi = 0, blkCnt = 0, eodCnt = 0, termCnt = 0, stCnt = 0, c0, i;
    assign hostIn = '{start: start, cmdSel: cmdSel, densitySelHi: 1'b0, densitySelLo: dLo,
        xferAck: pAck, terminate: pTerm | bTerm, sysReset: sysRst, muxSel: muxSel,
        data: dataOe ? dataOut : pData};
    tup_host_port #(.BLOCK_CYC(BLK), .EOD_CYC(EOD), .RST_PROC_CYC(RP)) i_tup_host_port (
        .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(4'hF), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .hostIn(hostIn),
        .dataOut(dataOut), .dataOe(dataOe), .busy(busy), .xferReq(xferReq),
        .expectingData(expectingData), .blockSensed(blockSensed),
        .endOfDataPulse(endOfDataPulse), .identBurstFlag(identBurstFlag),
        .tapeMarkFlag(tapeMarkFlag), .reject(reject), .statusMuxOut(statusMuxOut),
        .oscOut(oscOut), .engAtBot(atBot), .engIdOk(idOk), .engIdFail(idFail),
        .engIdGcr(1'b0), .engRdValid(rdValid), .engRdData(rdData), .engRdLast(rdLast),
        .engWrReq(wrReq), .engBlock(blk), .engTapeMark(tMark), .engDone(done),
        .engStatus(stat), .engStart(engStart), .engCmd(engCmd), .engGcr(engGcr),
        .engTerm(engTerm), .engAbort(engAbort), .engDiag(engDiag), .engRdTake(engRdTake),
        .engWrValid(engWrValid),
        .engWrData(engWrData));
    tup_host_model i_tup_host_model (.clk(clk), .xferReq(xferReq),
        .expectingData(expectingData), .lastChar(last), .slow(slow), .wrByte(wrByte),
        .ack(pAck), .term(pTerm), .data(pData));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        oscHi <= oscHi + oscOut;
        blkCnt <= blkCnt + blockSensed;
        eodCnt <= eodCnt + endOfDataPulse;
        termCnt <= termCnt + engTerm;
        stCnt <= stCnt + engStart;
        if (cycles == 40000) begin
            failures++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatI <= d;
        do @(posedge clk); while (wbAck !== 1'b1);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic cmd(input tup_cmd_t c, input logic lo);
        cmdSel <= c;
        dLo <= lo;
        start <= 1'b1;
        do @(posedge clk); while (busy !== 1'b1);
        start <= 1'b0;
        @(posedge clk);
    endtask : cmd
    task automatic pulse(input logic [4:0] m);
        {done, idOk, idFail, tMark, blk} <= m;
        @(posedge clk);
        {done, idOk, idFail, tMark, blk} <= 5'h00;
        repeat (3) @(posedge clk);
    endtask : pulse
    task automatic fin(input string n);
        pulse(P_DONE);
        do @(posedge clk); while (busy !== 1'b0);
        $display("test %s done", n);
    endtask : fin
    task automatic stop_test();
        $display("TB: %0d compared, %0d failures", nCompared, failures);
        if (failures == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        {clk, wbCyc, wbStb, wbWe, start, dLo, sysRst, bTerm, last, slow} = '0;
        {atBot, idOk, idFail, rdValid, rdLast, wrReq, blk, tMark, done} = '0;
        {wbAdr, wrByte, rdData, wbDatI, cmdSel, muxSel} = '0;
        stat = '0;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b0, 8'h04, 32'h0);
        chk(q[0], 1'b0);
        c0 = oscHi;
        repeat (400) @(posedge clk);
        chk(oscHi - c0, 200);
        wb(1'b1, 8'h00, 32'h6);
        wb(1'b1, 8'h0C, 32'h1);
        wb(1'b0, 8'h00, 32'h0);
        chk(q[2:0], 3'h6);
        atBot <= 1'b1;
        cmd(CMD_WRITE_BLOCK, 1'b1);
        chk(engGcr, 1'b1);
        chk(expectingData, 1'b1);
        chk(identBurstFlag, 1'b1);
        chk(engCmd, CMD_WRITE_BLOCK);
        pulse(P_IDOK);
        chk(identBurstFlag, 1'b0);
        c0 = termCnt;
        for (i = 0; i < 4; i++) begin
            b = 8'($random(seed));
            wrByte <= b;
            last <= (i == 3);
            slow <= i[0];
            wrReq <= 1'b1;
            do @(posedge clk); while (engWrValid !== 1'b1);
            chk(engWrData, b);
            wrReq <= 1'b0;
            repeat (10) @(posedge clk);
        end
        last <= 1'b0;
        chk(termCnt - c0, 1);
        chk(busy, 1'b1);
        fin("write");
        wb(1'b1, 8'h00, 32'h0);
        cmd(CMD_WRITE_BLOCK, 1'b1);
        chk(engGcr, 1'b0);
        pulse(P_IDOK);
        fin("panel");
        atBot <= 1'b0;
        cmd(CMD_READ_FWD, 1'b0);
        chk(expectingData, 1'b0);
        c0 = eodCnt;
        for (i = 0; i < 4; i++) begin
            b = 8'($random(seed));
            rdData <= b;
            rdLast <= (i == 3);
            rdValid <= 1'b1;
            do @(posedge clk); while (xferReq !== 1'b1);
            chk(dataOut, {~^b, b});
            chk(dataOe, 1'b1);
            do @(posedge clk); while (engRdTake !== 1'b1);
            rdValid <= 1'b0;
            repeat (8) @(posedge clk);
        end
        rdLast <= 1'b0;
        repeat (90) @(posedge clk);
        chk(eodCnt - c0, EOD);
        c0 = blkCnt;
        pulse(P_MARK);
        repeat (40) @(posedge clk);
        chk(blkCnt - c0, BLK);
        chk(tapeMarkFlag, 1'b1);
        fin("read");
        cmd(CMD_SENSE, 1'b0);
        fin("sense");
        chk(tapeMarkFlag, 1'b1);
        cmd(CMD_SPACE_FWD_BLOCK, 1'b0);
        chk(tapeMarkFlag, 1'b0);
        pulse(P_BLK);
        c0 = termCnt;
        bTerm <= 1'b1;
        repeat (6) @(posedge clk);
        bTerm <= 1'b0;
        chk(termCnt - c0, 1);
        stat <= 36'({$random(seed), $random(seed)});
        fin("space");
        for (i = 0; i < 8; i++) begin
            muxSel <= i[2:0];
            repeat (5) @(posedge clk);
            chk(statusMuxOut, i < 4 ? 9'((stat >> (27 - 9 * i))) : 9'h000);
        end
        atBot <= 1'b1;
        cmd(CMD_READ_FWD, 1'b0);
        pulse(P_FAIL);
        chk(busy, 1'b0);
        chk(reject, 1'b1);
        chk(identBurstFlag, 1'b1);
        wb(1'b1, 8'h00, 32'h6);
        chk(engDiag, 1'b1);
        cmd(CMD_WRITE_BLOCK, 1'b1);
        sysRst <= 1'b1;
        repeat (50) @(posedge clk);
        cmdSel <= CMD_READ_FWD;
        start <= 1'b1;
        repeat (50) @(posedge clk);
        chk(busy, 1'b1);
        chk(engAbort, 1'b1);
        chk(reject, 1'b0);
        sysRst <= 1'b0;
        repeat (RP) @(posedge clk);
        chk(busy, 1'b1);
        start <= 1'b0;
        repeat (10) @(posedge clk);
        chk(busy, 1'b0);
        chk(engCmd, CMD_WRITE_BLOCK);
        chk(engGcr, 1'b1);
        wb(1'b0, 8'h00, 32'h0);
        chk(q[2], 1'b0);
        chk(engDiag, 1'b0);
        chk(stCnt, 7);
        $display("test reset done");
        stop_test();
    end
endmodule : tup_host_port_tb
